// [core/dual_timer.sv]
// Purpose: two counter/timers with shared prescaler and special-register port
// Assumes: pins synchronous-safe via pin_sync; one register access per cycle
// Notes: read data registered, one cycle after rd; writes beat hardware counting
`timescale 1ns/1ps

// Operation
// - prescale field picks /12, /4, /48, ext/8
// - clock select: prescaler or system clock
// - counter mode counts event pin falling edges
// - events counted up to quarter clock rate
// - 13-bit: high byte plus low five bits
// - low byte top three bits undefined
// - 13-bit rollover sets overflow flag
// - interrupt when flag set and enabled
// - count only when run and gate allow
// - run bit never clears the count
// - second timer mirrors the first
// - 16-bit mode uses both bytes
// - auto-reload copies high into low
// - reload byte never changed by hardware
// - split low byte uses first timer controls
// - split high byte: second run, flag
// - split: second timer no pins, no flag
// - split: second runs unless mode three
// - mode field selects 13/16/reload/split
// - flag cleared on vector or software
module dual_timer (
  input wire logic mclk,
  input wire logic resetn,
  input wire timer_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic ext_clk_in,
  input wire logic gate_polarity_a,
  input wire logic gate_polarity_b,
  input wire logic irq_enable_a,
  input wire logic irq_enable_b,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  output logic irq_a,
  output logic irq_b,
  output logic overflow_pulse_b
);

  // ************************************************************
  // state and helpers
  // ************************************************************
  typedef struct packed {
    timer_pkg::timer_control_reg_t tctrl;
    timer_pkg::timer_mode_reg_t tmode;
    timer_pkg::timer_clock_config_t ckcfg;
    logic [7:0] low_byte_a;
    logic [7:0] high_byte_a;
    logic [7:0] low_byte_b;
    logic [7:0] high_byte_b;
    logic [5:0] pre_cnt;
    logic [2:0] ext_cnt;
    logic [7:0] rdata;
    logic ovp_b;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  logic [4:0] pin_level;
  logic [4:0] pin_fall;
  logic tick_pre;
  logic src_a;
  logic src_b;
  logic en_a;
  logic en_b;
  logic split_a;
  logic inc_hi;
  timer_pkg::step_t step_a;
  timer_pkg::step_t step_b;
  timer_pkg::step_t step_hi;

  function automatic logic [5:0] div_of(input logic [1:0] pf);
    unique case (pf)
      timer_pkg::PS_DIV12: div_of = timer_pkg::DIV_12;
      timer_pkg::PS_DIV4: div_of = timer_pkg::DIV_4;
      default: div_of = timer_pkg::DIV_48;
    endcase
  endfunction

  // one increment of a counter in a given mode; split counts the low byte only
  function automatic timer_pkg::step_t step(input logic [1:0] mode, input logic [7:0] lo,
                                            input logic [7:0] hi, input logic inc);
    logic [12:0] c13;
    logic [15:0] c16;
    step = '{low: lo, high: hi, ov: 1'b0};
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    if (inc) begin
      unique case (mode)
        timer_pkg::MODE_13: begin
          // upper low-byte bits are left as they are, software masks them
          step.high = c13[12:5];
          step.low = {lo[7:5], c13[4:0]};
          step.ov = ({hi, lo[4:0]} == 13'h1FFF);
        end
        timer_pkg::MODE_16: begin
          step.high = c16[15:8];
          step.low = c16[7:0];
          step.ov = ({hi, lo} == 16'hFFFF);
        end
        timer_pkg::MODE_RELOAD: begin
          step.low = (lo == 8'hFF) ? hi : lo + 8'h01;
          step.ov = (lo == 8'hFF);
        end
        timer_pkg::MODE_SPLIT: begin
          step.low = lo + 8'h01;
          step.ov = (lo == 8'hFF);
        end
      endcase
    end
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // events, gates and external clock: two flops then edge detect
  pin_sync #(.WIDTH(5)) u_pin_sync (
    .mclk(mclk),
    .resetn(resetn),
    .din({ext_clk_in, gate_input_b, gate_input_a, event_pin_b, event_pin_a}),
    .level(pin_level),
    .fall(pin_fall)
  );

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    // shared prescaler; a field change keeps the running count, ticking at once if it is already past the new end
    tick_pre = 1'b0;
    if (state_reg.ckcfg.prescale_field == timer_pkg::PS_EXT8) begin
      if (pin_fall[4]) begin
        tick_pre = (state_reg.ext_cnt == timer_pkg::EXT_DIV_LAST);
        state_next.ext_cnt = state_reg.ext_cnt + 3'h1;
      end
    end else begin
      tick_pre = (state_reg.pre_cnt >= div_of(state_reg.ckcfg.prescale_field) - 6'h01);
      state_next.pre_cnt = tick_pre ? 6'h00 : state_reg.pre_cnt + 6'h01;
    end
    split_a = (state_reg.tmode.mode_a == timer_pkg::MODE_SPLIT);
    // first timer: pin edge or selected clock, run bit and gate
    src_a = state_reg.tmode.counter_select_a ? pin_fall[0]
          : (state_reg.ckcfg.sysclk_select_a | tick_pre);
    en_a = state_reg.tctrl.run_bit_a & (~state_reg.tmode.gate_select_a
         | (pin_level[2] == gate_polarity_a));
    step_a = step(state_reg.tmode.mode_a, state_reg.low_byte_a, state_reg.high_byte_a,
                  en_a & src_a);
    // split high byte: internal clock only, under the second run bit
    inc_hi = split_a & state_reg.tctrl.run_bit_b
           & (state_reg.ckcfg.sysclk_select_a | tick_pre);
    step_hi = step(timer_pkg::MODE_SPLIT, state_reg.high_byte_a, 8'h00, inc_hi);
    // second timer: no pin counting and mode-driven run while first is split
    src_b = (state_reg.tmode.counter_select_b & ~split_a) ? pin_fall[1]
          : (state_reg.ckcfg.sysclk_select_b | tick_pre);
    en_b = split_a ? 1'b1
         : state_reg.tctrl.run_bit_b & (~state_reg.tmode.gate_select_b
         | (pin_level[3] == gate_polarity_b));
    en_b = en_b & (state_reg.tmode.mode_b != timer_pkg::MODE_SPLIT);
    step_b = step(state_reg.tmode.mode_b, state_reg.low_byte_b, state_reg.high_byte_b,
                  en_b & src_b);
    state_next.low_byte_a = step_a.low;
    state_next.high_byte_a = split_a ? step_hi.low : step_a.high;
    state_next.low_byte_b = step_b.low;
    state_next.high_byte_b = step_b.high;
    state_next.ovp_b = step_b.ov;
    // register writes win over counting in the same cycle
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        timer_pkg::ADDR_TCTRL: state_next.tctrl = sfr_req.wdata;
        timer_pkg::ADDR_TMODE: state_next.tmode = sfr_req.wdata;
        timer_pkg::ADDR_CKCFG: state_next.ckcfg = sfr_req.wdata;
        timer_pkg::ADDR_LOW_A: state_next.low_byte_a = sfr_req.wdata;
        timer_pkg::ADDR_HIGH_A: state_next.high_byte_a = sfr_req.wdata;
        timer_pkg::ADDR_LOW_B: state_next.low_byte_b = sfr_req.wdata;
        timer_pkg::ADDR_HIGH_B: state_next.high_byte_b = sfr_req.wdata;
        default: ;
      endcase
    end
    // vector clears, then hardware set wins over any clear
    if (irq_ack_a) state_next.tctrl.overflow_flag_a = 1'b0;
    if (irq_ack_b) state_next.tctrl.overflow_flag_b = 1'b0;
    if (step_a.ov) state_next.tctrl.overflow_flag_a = 1'b1;
    if (split_a ? step_hi.ov : step_b.ov) state_next.tctrl.overflow_flag_b = 1'b1;
    // registered read port, unmapped addresses read zero
    state_next.rdata = 8'h00;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        timer_pkg::ADDR_TCTRL: state_next.rdata = state_reg.tctrl;
        timer_pkg::ADDR_TMODE: state_next.rdata = state_reg.tmode;
        timer_pkg::ADDR_CKCFG: state_next.rdata = state_reg.ckcfg;
        timer_pkg::ADDR_LOW_A: state_next.rdata = state_reg.low_byte_a;
        timer_pkg::ADDR_HIGH_A: state_next.rdata = state_reg.high_byte_a;
        timer_pkg::ADDR_LOW_B: state_next.rdata = state_reg.low_byte_b;
        timer_pkg::ADDR_HIGH_B: state_next.rdata = state_reg.high_byte_b;
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{tctrl: timer_pkg::RST_TCTRL, tmode: timer_pkg::RST_TMODE,
                     ckcfg: timer_pkg::RST_CKCFG, low_byte_a: timer_pkg::RST_COUNT,
                     high_byte_a: timer_pkg::RST_COUNT, low_byte_b: timer_pkg::RST_COUNT,
                     high_byte_b: timer_pkg::RST_COUNT, pre_cnt: 6'h00, ext_cnt: 3'h0,
                     rdata: 8'h00, ovp_b: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // interrupt requests follow the flags through the enables
  assign irq_a = state_reg.tctrl.overflow_flag_a & irq_enable_a;
  assign irq_b = state_reg.tctrl.overflow_flag_b & irq_enable_b;
  assign sfr_rdata = state_reg.rdata;
  assign overflow_pulse_b = state_reg.ovp_b;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_div12;
    (tick_pre && state_reg.ckcfg.prescale_field == timer_pkg::PS_DIV12 && !sfr_req.wr)
      ##1 (!sfr_req.wr) [*8] |-> ##4 (tick_pre || $past(sfr_req.wr, 1)
      || $past(sfr_req.wr, 2) || $past(sfr_req.wr, 3));
  endproperty
  a_div12: assert property (p_div12) else $error("prescaler /12 period wrong");

  property p_count16;
    (state_reg.tmode.mode_a == timer_pkg::MODE_16 && en_a && src_a && !sfr_req.wr)
      |=> ({state_reg.high_byte_a, state_reg.low_byte_a}
           == $past({state_reg.high_byte_a, state_reg.low_byte_a}) + 16'h0001);
  endproperty
  a_count16: assert property (p_count16) else $error("16-bit count missed");

  property p_hold;
    (!state_reg.tctrl.run_bit_a && !split_a && !sfr_req.wr)
      |=> $stable(state_reg.low_byte_a) && $stable(state_reg.high_byte_a);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped timer changed");

  property p_ov13;
    (state_reg.tmode.mode_a == timer_pkg::MODE_13 && en_a && src_a
     && {state_reg.high_byte_a, state_reg.low_byte_a[4:0]} == 13'h1FFF)
      |=> state_reg.tctrl.overflow_flag_a;
  endproperty
  a_ov13: assert property (p_ov13) else $error("13-bit rollover flag lost");

  property p_reload;
    (state_reg.tmode.mode_a == timer_pkg::MODE_RELOAD && en_a && src_a
     && state_reg.low_byte_a == 8'hFF && !sfr_req.wr)
      |=> state_reg.low_byte_a == state_reg.high_byte_a && state_reg.tctrl.overflow_flag_a;
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload failed");

  property p_keep_reload;
    (state_reg.tmode.mode_a == timer_pkg::MODE_RELOAD && !sfr_req.wr)
      |=> $stable(state_reg.high_byte_a);
  endproperty
  a_keep_reload: assert property (p_keep_reload) else $error("reload byte touched");

  // an overflow must reach the request line through the flag, one cycle later
  property p_irq;
    step_a.ov ##1 irq_enable_a |-> irq_a;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  property p_split_flag;
    (split_a && !state_reg.tctrl.overflow_flag_b && !step_hi.ov && !sfr_req.wr)
      |=> !state_reg.tctrl.overflow_flag_b;
  endproperty
  a_split_flag: assert property (p_split_flag) else $error("second flag set in split");

  property p_ack;
    (irq_ack_a && !step_a.ov && !sfr_req.wr) |=> !state_reg.tctrl.overflow_flag_a;
  endproperty
  a_ack: assert property (p_ack) else $error("vector did not clear flag");

  c_reload: cover property (state_reg.tmode.mode_a == timer_pkg::MODE_RELOAD && step_a.ov);
  c_split_hi: cover property (step_hi.ov);
  c_event: cover property (state_reg.tmode.counter_select_a && en_a && pin_fall[0]);
  c_ov13: cover property (state_reg.tmode.mode_b == timer_pkg::MODE_13 && step_b.ov);

endmodule // dual_timer

// [core/pin_sync.sv]
// Purpose: two-flop synchroniser with falling-edge detect per input pin
// Assumes: pins held at least two clocks per level
// Notes: fall is a one-cycle pulse, taken after the second flop only
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } sync_state_t;

  sync_state_t sync_reg;
  sync_state_t sync_next;

  // first stage only feeds the second; edge logic looks at later stages
  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = din;
    sync_next.stable = sync_reg.meta;
    sync_next.prev = sync_reg.stable;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.stable;
  assign fall = sync_reg.prev & ~sync_reg.stable;

endmodule // pin_sync

// [core/timer_pkg.sv]
// Purpose: shared constants and carrier types for the dual counter/timer block
// Assumes: byte-wide special-register port, one clock domain
// Notes: register addresses, reset values, modes and prescale divisors live here
package timer_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_TCTRL = 8'h88;
  localparam logic [7:0] ADDR_TMODE = 8'h89;
  localparam logic [7:0] ADDR_LOW_A = 8'h8A;
  localparam logic [7:0] ADDR_LOW_B = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_A = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_B = 8'h8D;
  localparam logic [7:0] ADDR_CKCFG = 8'h8E;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_TCTRL = 8'h00;
  localparam logic [7:0] RST_TMODE = 8'h00;
  localparam logic [7:0] RST_CKCFG = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ************************************************************
  // mode and prescale encodings, divisors
  // ************************************************************
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_EXT8 = 2'h3;
  localparam logic [5:0] DIV_12 = 6'h0C;
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7; // external clock divided by 8

  // ************************************************************
  // register layouts and carriers
  // ************************************************************
  typedef struct packed {
    logic overflow_flag_b;
    logic run_bit_b;
    logic overflow_flag_a;
    logic run_bit_a;
    logic [3:0] ext_irq_bits;
  } timer_control_reg_t;

  typedef struct packed {
    logic gate_select_b;
    logic counter_select_b;
    logic [1:0] mode_b;
    logic gate_select_a;
    logic counter_select_a;
    logic [1:0] mode_a;
  } timer_mode_reg_t;

  typedef struct packed {
    logic [3:0] other_timer_bits;
    logic sysclk_select_b;
    logic sysclk_select_a;
    logic [1:0] prescale_field;
  } timer_clock_config_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ov;
  } step_t;

endpackage

// [verif/pin_model.sv]
// Purpose: far-side model driving the event, gate and external clock pins
// Assumes: the bench calls its tasks; one clock domain
// Notes: every level is held two clocks, so the fastest rate is a quarter clock
`timescale 1ns/1ps
module pin_model (
  input wire logic mclk,
  output logic event_pin_a,
  output logic event_pin_b,
  output logic gate_input_a,
  output logic gate_input_b,
  output logic ext_clk_in
);
  // idle high, so the first drop is a real falling edge; clock stands still between bursts
  initial begin
    event_pin_a = 1'b1;
    event_pin_b = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
    ext_clk_in = 1'b1;
  end

  // n falling edges: sel 0 pin a, 1 pin b, 2 external clock
  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge mclk);
      case (sel)
        0: event_pin_a <= i[0];
        1: event_pin_b <= i[0];
        default: ext_clk_in <= i[0];
      endcase
      @(posedge mclk); // each level stands two clocks
    end
  endtask

  // gate level change, held until the next call
  task automatic set_gate(input int sel, input logic lvl);
    @(posedge mclk);
    if (sel == 0) gate_input_a <= lvl;
    else gate_input_b <= lvl;
  endtask
endmodule // pin_model

// [verif/tb_dual_timer.sv]
// Purpose: self-checking bench for the dual counter/timer through its register port
// Assumes: read data one cycle after the read strobe; pin effects seen within four clocks
// Notes: prescaled counts checked as ranges since the prescaler phase is free
`timescale 1ns/1ps
module tb_dual_timer;
  logic mclk, resetn;
  timer_pkg::sfr_req_t sfr_req;
  logic [7:0] sfr_rdata, rd_val, keep;
  logic event_pin_a, event_pin_b, gate_input_a, gate_input_b, ext_clk_in;
  logic gate_polarity_a, gate_polarity_b, irq_enable_a, irq_enable_b, irq_ack_a, irq_ack_b;
  logic irq_a, irq_b, overflow_pulse_b;
  logic [5:0] d;
  int n_errors = 0;
  int checks_done = 0;
  int n_ovb = 0;
  int base;

  dual_timer u_dual_timer (.mclk(mclk), .resetn(resetn), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .event_pin_a(event_pin_a), .event_pin_b(event_pin_b),
    .gate_input_a(gate_input_a), .gate_input_b(gate_input_b), .ext_clk_in(ext_clk_in),
    .gate_polarity_a(gate_polarity_a), .gate_polarity_b(gate_polarity_b),
    .irq_enable_a(irq_enable_a), .irq_enable_b(irq_enable_b), .irq_ack_a(irq_ack_a),
    .irq_ack_b(irq_ack_b), .irq_a(irq_a), .irq_b(irq_b), .overflow_pulse_b(overflow_pulse_b));
  pin_model u_pin_model (.mclk(mclk), .event_pin_a(event_pin_a), .event_pin_b(event_pin_b),
    .gate_input_a(gate_input_a), .gate_input_b(gate_input_b), .ext_clk_in(ext_clk_in));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // overflow pulses of the second timer, counted as they go by
  always @(negedge mclk) begin
    if (overflow_pulse_b === 1'b1) n_ovb++;
  end

  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_range(input logic [7:0] got, input int lo, input int hi);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("ERROR t=%0t count %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // one write; the strobe drops a cycle later, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    sfr_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge mclk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    sfr_req <= '0;
    #1 rd_val = sfr_rdata;
    check8(rd_val & m, exp, "read");
  endtask

  task automatic ev(input int sel, input int n);
    u_pin_model.pulses(sel, n);
    repeat (4) @(posedge mclk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    resetn = 1'b0;
    sfr_req = '0;
    {gate_polarity_a, gate_polarity_b, irq_enable_a, irq_enable_b} = 4'h0;
    {irq_ack_a, irq_ack_b} = 2'h0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hFF, timer_pkg::RST_TCTRL);
    rd_chk(timer_pkg::ADDR_TMODE, 8'hFF, timer_pkg::RST_TMODE);
    rd_chk(timer_pkg::ADDR_CKCFG, 8'hFF, timer_pkg::RST_CKCFG);
    wr(8'h90, 8'hFF);
    rd_chk(8'h90, 8'hFF, 8'h00);
    wr(timer_pkg::ADDR_CKCFG, 8'hA0);
    rd_chk(timer_pkg::ADDR_CKCFG, 8'hFF, 8'hA0);
    // 13-bit counter on pin a, loaded before run
    wr(timer_pkg::ADDR_TMODE, 8'h04);
    wr(timer_pkg::ADDR_HIGH_A, 8'hFF);
    wr(timer_pkg::ADDR_LOW_A, 8'hFE);
    wr(timer_pkg::ADDR_TCTRL, 8'h10);
    irq_enable_a <= 1'b1;
    ev(0, 1);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'h1F, 8'h1F);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h10);
    ev(0, 1);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'h1F, 8'h00);
    rd_chk(timer_pkg::ADDR_HIGH_A, 8'hFF, 8'h00);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h30);
    check8({7'h00, irq_a}, 8'h01, "irq a");
    @(posedge mclk);
    irq_ack_a <= 1'b1;
    @(posedge mclk);
    irq_ack_a <= 1'b0;
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h10);
    check8({7'h00, irq_a}, 8'h00, "irq a after ack");
    // 16-bit counter qualified by an active-high gate
    wr(timer_pkg::ADDR_TMODE, 8'h0D);
    gate_polarity_a <= 1'b1;
    wr(timer_pkg::ADDR_LOW_A, 8'hFF);
    wr(timer_pkg::ADDR_HIGH_A, 8'h12);
    ev(0, 2);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'hFF, 8'hFF);
    u_pin_model.set_gate(0, 1'b1);
    repeat (4) @(posedge mclk);
    ev(0, 1);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'hFF, 8'h00);
    rd_chk(timer_pkg::ADDR_HIGH_A, 8'hFF, 8'h13);
    wr(timer_pkg::ADDR_TCTRL, 8'h00);
    ev(0, 1);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'hFF, 8'h00);
    // 8-bit auto-reload on pin a
    wr(timer_pkg::ADDR_TMODE, 8'h06);
    wr(timer_pkg::ADDR_HIGH_A, 8'hF0);
    wr(timer_pkg::ADDR_LOW_A, 8'hFE);
    wr(timer_pkg::ADDR_TCTRL, 8'h10);
    ev(0, 2);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'hFF, 8'hF0);
    rd_chk(timer_pkg::ADDR_HIGH_A, 8'hFF, 8'hF0);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h30);
    ev(0, 1);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'hFF, 8'hF1);
    wr(timer_pkg::ADDR_TCTRL, 8'h00);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h00);
    // second timer: 16-bit counter, active-low gate
    wr(timer_pkg::ADDR_TMODE, 8'hD0);
    irq_enable_b <= 1'b1;
    wr(timer_pkg::ADDR_LOW_B, 8'hFF);
    wr(timer_pkg::ADDR_HIGH_B, 8'hFF);
    wr(timer_pkg::ADDR_TCTRL, 8'h40);
    ev(1, 1);
    rd_chk(timer_pkg::ADDR_LOW_B, 8'hFF, 8'h00);
    rd_chk(timer_pkg::ADDR_HIGH_B, 8'hFF, 8'h00);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'hC0);
    check8({7'h00, irq_b}, 8'h01, "irq b");
    check8(n_ovb[7:0], 8'h01, "overflow pulse b");
    @(posedge mclk);
    irq_ack_b <= 1'b1;
    @(posedge mclk);
    irq_ack_b <= 1'b0;
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h40);
    check8({7'h00, irq_b}, 8'h00, "irq b after ack");
    u_pin_model.set_gate(1, 1'b1);
    repeat (4) @(posedge mclk);
    ev(1, 1);
    rd_chk(timer_pkg::ADDR_LOW_B, 8'hFF, 8'h00);
    // split: second timer free-runs on system clock, no flag
    wr(timer_pkg::ADDR_TCTRL, 8'h00);
    wr(timer_pkg::ADDR_CKCFG, 8'h0C);
    wr(timer_pkg::ADDR_TMODE, 8'h57);
    wr(timer_pkg::ADDR_LOW_B, 8'hF0);
    wr(timer_pkg::ADDR_HIGH_B, 8'hFF);
    base = n_ovb;
    for (int i = 0; i < 100 && n_ovb == base; i++) @(posedge mclk);
    check8({7'h00, n_ovb != base}, 8'h01, "split b pulse");
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'h00);
    wr(timer_pkg::ADDR_TMODE, 8'h77);
    rd_chk(timer_pkg::ADDR_LOW_B, 8'h00, 8'h00);
    keep = rd_val;
    repeat (10) @(posedge mclk);
    rd_chk(timer_pkg::ADDR_LOW_B, 8'hFF, keep);
    wr(timer_pkg::ADDR_HIGH_A, 8'hF0);
    wr(timer_pkg::ADDR_LOW_A, 8'hFF);
    wr(timer_pkg::ADDR_TCTRL, 8'h50);
    repeat (30) @(posedge mclk);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'hD0);
    ev(0, 1);
    rd_chk(timer_pkg::ADDR_LOW_A, 8'hFF, 8'h00);
    rd_chk(timer_pkg::ADDR_TCTRL, 8'hF0, 8'hF0);
    // prescaler codes on a 16-bit timer
    wr(timer_pkg::ADDR_TCTRL, 8'h00);
    wr(timer_pkg::ADDR_TMODE, 8'h01);
    for (int c = 0; c < 4; c++) begin
      d = (c == 0) ? timer_pkg::DIV_12 : (c == 1) ? timer_pkg::DIV_4 : timer_pkg::DIV_48;
      wr(timer_pkg::ADDR_CKCFG, 8'(c));
      repeat (100) @(posedge mclk); // lets the old period finish
      wr(timer_pkg::ADDR_LOW_A, 8'h00);
      wr(timer_pkg::ADDR_TCTRL, 8'h10);
      if (c == 3) u_pin_model.pulses(2, 16);
      else repeat (8 * d - 2) @(posedge mclk);
      wr(timer_pkg::ADDR_TCTRL, 8'h00);
      rd_chk(timer_pkg::ADDR_LOW_A, 8'h00, 8'h00);
      if (c == 3) check_range(rd_val, 1, 2);
      else check_range(rd_val, 7, 9);
    end
    // system clock select, then ignored in counter mode
    for (int m = 0; m < 2; m++) begin
      wr(timer_pkg::ADDR_CKCFG, 8'h04);
      wr(timer_pkg::ADDR_TMODE, m ? 8'h05 : 8'h01);
      wr(timer_pkg::ADDR_LOW_A, 8'h00);
      wr(timer_pkg::ADDR_TCTRL, 8'h10);
      repeat (18) @(posedge mclk);
      wr(timer_pkg::ADDR_TCTRL, 8'h00);
      rd_chk(timer_pkg::ADDR_LOW_A, 8'h00, 8'h00);
      check_range(rd_val, m ? 0 : 19, m ? 0 : 21);
    end
    complete_run();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
endmodule // tb_dual_timer
